/* File: logic/tcpd_regs.vh */
`ifndef TCPD_REGS_VH
`define TCPD_REGS_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TCPD_OFF_PKT0      8'h00
`define TCPD_OFF_PKT1      8'h04
`define TCPD_OFF_PKT2      8'h08
`define TCPD_OFF_PKT3      8'h0C
`define TCPD_OFF_CTRL      8'h10
`define TCPD_OFF_STATUS    8'h14
`define TCPD_OFF_XST0      8'h18
`define TCPD_OFF_XST3      8'h1C
`define TCPD_OFF_CHAR      8'h20
`define TCPD_OFF_XCHAR     8'h24
`define TCPD_OFF_TAPE      8'h28
`define TCPD_OFF_ADDR      8'h2C
`define TCPD_OFF_COUNT     8'h30
// ----------------------------------------------------------------------
// Header fields
// ----------------------------------------------------------------------
`define TCPD_HDR_OWN       15
`define TCPD_CODE_READ     5'h01
`define TCPD_CODE_WCHAR    5'h04
`define TCPD_CODE_WRITE    5'h05
`define TCPD_CODE_POS      5'h08
`define TCPD_CODE_CTL      5'h0A
`define TCPD_MODE_0        4'h0
`define TCPD_MODE_1        4'h1
`define TCPD_MODE_2        4'h2
`define TCPD_MODE_3        4'h3
`define TCPD_FMT_NOINT     3'h0
`define TCPD_FMT_INT       3'h4
// ----------------------------------------------------------------------
// Characteristics fields
// ----------------------------------------------------------------------
`define TCPD_CH_DBL        7
`define TCPD_CH_FIRST      6
`define TCPD_CH_REL        4
`define TCPD_XC_SPEED      5
// ----------------------------------------------------------------------
// Termination classes
// ----------------------------------------------------------------------
`define TCPD_TC_NORMAL     3'h0
`define TCPD_TC_ALERT      3'h2
`define TCPD_TC_REJECT     3'h3
// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define TCPD_X0_TMK        15
`define TCPD_X0_RLS        14
`define TCPD_X0_RLL        12
`define TCPD_X0_LET        11
`define TCPD_X0_NEF        8
`define TCPD_X0_ILA        7
`define TCPD_X0_ILC        6
`define TCPD_X0_EOT        0
`define TCPD_X3_RIB        0
// ----------------------------------------------------------------------
// Tape event inputs (TAPE register bits, write pulses)
// ----------------------------------------------------------------------
`define TCPD_EV_DONE       0
`define TCPD_EV_MARK       1
`define TCPD_EV_BOTPASS    2
`define TCPD_EV_ATBOT      3
`define TCPD_EV_ATEOT      4
`define TCPD_EV_EOTREV     5
`define TCPD_EV_DBLMARK    6
`define TCPD_EV_FIRSTMK    7
`define TCPD_FULL_COUNT    17'h10000
`endif

/* File: logic/tcpd_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "tcpd_regs.vh"

module tcpd_top
(
   input  wire        hclk,        // System clock
   input  wire        hresetn,     // Async reset, active low
   input  wire        hsel,        // Slave select
   input  wire [31:0] haddr,       // Address
   input  wire [1:0]  htrans,      // Transfer type
   input  wire        hwrite,      // Write strobe
   input  wire [2:0]  hsize,       // Transfer size
   input  wire [31:0] hwdata,      // Write data
   input  wire        hready,      // Bus ready in
   input  wire        ext_en,      // Extended features strap (pin)
   output reg  [31:0] hrdata,      // Read data
   output reg         hreadyout,   // Always ready
   output reg         hresp,       // Always OKAY
   output reg         motion_go,   // Pulse: start tape operation
   output reg         buf_owned,   // Device owns message buffer
   output reg         subsystem_ready, // Ready for a command
   output reg         done_irq,    // Pulse: completion interrupt
   output reg  [2:0]  unit_sel,    // Selected transport
   output reg         high_speed   // High transport speed
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   // High address word legal for current extended setting
   function hi_ok;
      input [15:0] w;
      input        ext;
      begin
         if (ext)
            hi_ok = (w[15:6] == 10'h000);
         else
            hi_ok = (w[15:2] == 14'h0000);
      end
   endfunction

   // Byte count word to real length
   function [16:0] blen;
      input [15:0] c;
      begin
         if (c == 16'h0000)
            blen = `TCPD_FULL_COUNT;
         else
            blen = {1'b0, c};
      end
   endfunction

   // -------------------------------------------------------------------
   // Pin synchroniser
   // -------------------------------------------------------------------
   reg ext_s1_r;
   reg ext_r;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_s1_r <= 1'b0;
         ext_r    <= 1'b0;
      end
      else
      begin
         ext_s1_r <= ext_en;
         ext_r    <= ext_s1_r;
      end
   end

   // -------------------------------------------------------------------
   // AHB address phase capture
   // -------------------------------------------------------------------
   reg        wr_pend_r;
   reg        rd_pend_r;
   reg [7:0]  aoff_r;
   wire       acc = hsel & hready & htrans[1];

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         aoff_r    <= 8'h00;
      end
      else
      begin
         wr_pend_r <= acc & hwrite;
         rd_pend_r <= acc & ~hwrite;
         aoff_r    <= haddr[7:0];
      end
   end

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg [15:0] pkt_r [0:3];        // Command packet words
   reg        chars_ok_r;         // Characteristics accepted
   reg [15:0] char_r;             // Characteristics mode word
   reg [15:0] xchar_r;            // Extended characteristics word
   reg [15:0] xst0_r;             // Extended status word zero
   reg [15:0] xst3_r;             // Extended status word three
   reg [2:0]  tclass_r;           // Termination class
   reg        busy_r;             // Operation under way
   reg        ie_r;               // Completion interrupt enabled
   reg [21:0] xaddr_r;            // Transfer address
   reg [16:0] xcount_r;           // Bytes to move
   reg        at_bot_r;           // Tape sits at load point
   reg        eot_r;              // End of tape latched
   reg        is_read_r;
   reg        is_write_r;
   reg        is_skip_r;
   integer    i;

   wire [15:0] hdr   = pkt_r[0];
   wire [4:0]  code  = hdr[4:0];
   wire [3:0]  mode  = hdr[11:8];
   wire [2:0]  fmt   = hdr[7:5];
   wire        go    = wr_pend_r & (aoff_r == `TCPD_OFF_CTRL) & hwdata[0];
   wire        ev_wr = wr_pend_r & (aoff_r == `TCPD_OFF_TAPE);
   wire [7:0]  ev    = hwdata[7:0];
   wire        fmt_ok = (fmt == `TCPD_FMT_NOINT) | (fmt == `TCPD_FMT_INT);
   wire [21:0] full_addr = ext_r ? {pkt_r[2][5:0], pkt_r[1]}
                                 : {4'h0, pkt_r[2][1:0], pkt_r[1]};
   // Commands that go on to tape motion; all others end at once
   wire        rd_start = (code == `TCPD_CODE_READ) & hi_ok(pkt_r[2], ext_r)
                        & ((mode == `TCPD_MODE_0) |
                           ((mode == `TCPD_MODE_1) & ~at_bot_r));
   wire        wr_start = (code == `TCPD_CODE_WRITE) & (mode == `TCPD_MODE_0)
                        & hi_ok(pkt_r[2], ext_r);
   wire        sk_start = (code == `TCPD_CODE_POS) &
                          ((mode == `TCPD_MODE_2) | (mode == `TCPD_MODE_3));
   wire        starts   = fmt_ok & chars_ok_r & (rd_start | wr_start | sk_start);

   // -------------------------------------------------------------------
   // Command decode and tape event handling
   // -------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (i = 0; i < 4; i = i + 1)
            pkt_r[i] <= 16'h0000;
         chars_ok_r      <= 1'b0;
         char_r          <= 16'h0000;
         xchar_r         <= 16'h0000;
         xst0_r          <= 16'h0000;
         xst3_r          <= 16'h0000;
         tclass_r        <= `TCPD_TC_NORMAL;
         busy_r          <= 1'b0;
         ie_r            <= 1'b0;
         xaddr_r         <= 22'h000000;
         xcount_r        <= 17'h00000;
         at_bot_r        <= 1'b1;
         eot_r           <= 1'b0;
         is_read_r       <= 1'b0;
         is_write_r      <= 1'b0;
         is_skip_r       <= 1'b0;
         motion_go       <= 1'b0;
         buf_owned       <= 1'b0;
         subsystem_ready <= 1'b1;
         done_irq        <= 1'b0;
         unit_sel        <= 3'h0;
         high_speed      <= 1'b0;
      end
      else
      begin
         motion_go <= 1'b0;
         done_irq  <= 1'b0;
         // Packet words written by the fetch side
         if (wr_pend_r && !busy_r && aoff_r[7:4] == 4'h0)
            pkt_r[aoff_r[3:2]] <= hwdata[15:0];
         if (wr_pend_r && aoff_r == `TCPD_OFF_CHAR && !busy_r)
            char_r <= hwdata[15:0];
         // Extended word: bits 4..3 ignored
         if (wr_pend_r && aoff_r == `TCPD_OFF_XCHAR && !busy_r && ext_r)
         begin
            xchar_r    <= hwdata[15:0];
            high_speed <= hwdata[`TCPD_XC_SPEED];
            unit_sel   <= hwdata[2:0];
         end
         // Whole packet present before anything is checked
         if (go && !busy_r)
         begin
            xst0_r <= {15'h0000, eot_r};  // End flag survives
            xst3_r <= 16'h0000;
            ie_r   <= (fmt == `TCPD_FMT_INT);
            if (hdr[`TCPD_HDR_OWN])
               buf_owned <= 1'b1;
            subsystem_ready <= 1'b0;
            // Code and mode select the command
            if (!fmt_ok)
               tclass_r <= `TCPD_TC_REJECT;
            else if (code == `TCPD_CODE_WCHAR && mode == `TCPD_MODE_0)
            begin
               // Odd or out-of-range address rejected
               if (pkt_r[1][0] || !hi_ok(pkt_r[2], ext_r))
                  tclass_r <= `TCPD_TC_REJECT;
               else
               begin
                  chars_ok_r <= 1'b1;
                  xaddr_r    <= full_addr;
                  tclass_r   <= `TCPD_TC_NORMAL;
               end
            end
            else if (!chars_ok_r)
               tclass_r <= `TCPD_TC_REJECT;
            else if (code == `TCPD_CODE_READ)
            begin
               // Reverse-transfer and swap bits unread
               if (!hi_ok(pkt_r[2], ext_r))
               begin
                  tclass_r <= `TCPD_TC_REJECT;
                  xst0_r[`TCPD_X0_ILA] <= 1'b1;
               end
               else if (mode == `TCPD_MODE_1 && at_bot_r)
               begin
                  tclass_r <= `TCPD_TC_REJECT;
                  xst0_r[`TCPD_X0_NEF] <= 1'b1;
               end
               else if (mode != `TCPD_MODE_0 && mode != `TCPD_MODE_1)
               begin
                  tclass_r <= `TCPD_TC_REJECT;
                  xst0_r[`TCPD_X0_ILC] <= 1'b1;
               end
               else
               begin
                  xaddr_r   <= full_addr;
                  xcount_r  <= blen(pkt_r[3]);
                  is_read_r <= 1'b1;
                  busy_r    <= 1'b1;
                  motion_go <= 1'b1;
               end
            end
            else if (code == `TCPD_CODE_WRITE)
            begin
               if (mode != `TCPD_MODE_0)
               begin
                  tclass_r <= `TCPD_TC_REJECT;
                  xst0_r[`TCPD_X0_ILC] <= 1'b1;
               end
               else if (!hi_ok(pkt_r[2], ext_r))
               begin
                  tclass_r <= `TCPD_TC_REJECT;
                  xst0_r[`TCPD_X0_ILA] <= 1'b1;
               end
               else
               begin
                  // Low byte first, swap bit unused
                  xaddr_r    <= full_addr;
                  xcount_r   <= blen(pkt_r[3]);
                  is_write_r <= 1'b1;
                  busy_r     <= 1'b1;
                  motion_go  <= 1'b1;
               end
            end
            else if (code == `TCPD_CODE_POS &&
                     (mode == `TCPD_MODE_2 || mode == `TCPD_MODE_3))
            begin
               is_skip_r <= 1'b1;
               busy_r    <= 1'b1;
               motion_go <= 1'b1;
            end
            else if (code == `TCPD_CODE_CTL && mode == `TCPD_MODE_0)
            begin
               // Release: ready only, or interrupt as enabled
               tclass_r <= `TCPD_TC_NORMAL;
               done_irq <= char_r[`TCPD_CH_REL];
            end
            else
            begin
               tclass_r <= `TCPD_TC_REJECT;
               xst0_r[`TCPD_X0_ILC] <= 1'b1;
            end
            // Immediate ends: ready again, interrupt as the format asks, except for the control code
            if (!starts)
            begin
               subsystem_ready <= 1'b1;
               if (fmt_ok && code != `TCPD_CODE_CTL)
                  done_irq <= (fmt == `TCPD_FMT_INT);
            end
         end
         // Tape events while busy
         else if (ev_wr && busy_r)
         begin
            if (ev[`TCPD_EV_ATEOT])
               eot_r <= 1'b1;
            if (ev[`TCPD_EV_BOTPASS])
            begin
               xst3_r[`TCPD_X3_RIB] <= 1'b1;
               at_bot_r <= 1'b1;
            end
            if (is_skip_r && !ev[`TCPD_EV_DONE])
            begin
               // Double-mark and first-mark stops
               if (char_r[`TCPD_CH_DBL] && (ev[`TCPD_EV_DBLMARK] ||
                   (char_r[`TCPD_CH_FIRST] && ev[`TCPD_EV_FIRSTMK])))
               begin
                  xst0_r[`TCPD_X0_LET] <= 1'b1;
                  busy_r <= 1'b0;
                  is_skip_r <= 1'b0;
                  subsystem_ready <= 1'b1;
                  tclass_r <= `TCPD_TC_NORMAL;
                  done_irq <= ie_r;
               end
            end
            else if (ev[`TCPD_EV_DONE])
            begin
               busy_r     <= 1'b0;
               is_read_r  <= 1'b0;
               is_write_r <= 1'b0;
               is_skip_r  <= 1'b0;
               subsystem_ready <= 1'b1;
               done_irq   <= ie_r;
               at_bot_r   <= ev[`TCPD_EV_ATBOT];
               tclass_r   <= `TCPD_TC_NORMAL;
               if (is_read_r && ev[`TCPD_EV_MARK])
               begin
                  xst0_r[`TCPD_X0_TMK] <= 1'b1;
                  xst0_r[`TCPD_X0_RLS] <= 1'b1;
                  xcount_r <= 17'h00000;
                  tclass_r <= `TCPD_TC_ALERT;
               end
               else if (is_read_r && hwdata[31:15] != xcount_r)
               begin
                  if (hwdata[31:15] < xcount_r)
                  begin
                     xst0_r[`TCPD_X0_RLS] <= 1'b1;
                     xcount_r <= hwdata[31:15];
                  end
                  else
                     xst0_r[`TCPD_X0_RLL] <= 1'b1;
                  tclass_r <= `TCPD_TC_ALERT;
               end
               if (ev[`TCPD_EV_BOTPASS])
                  tclass_r <= `TCPD_TC_ALERT;
               if (is_write_r && (eot_r || ev[`TCPD_EV_ATEOT]))
               begin
                  xst0_r[`TCPD_X0_EOT] <= 1'b1;
                  tclass_r <= `TCPD_TC_ALERT;
               end
            end
         end
         // While busy, a new end-of-tape report wins over a reverse pass; while idle the reverse pass clears the latch
         if (ev_wr && ev[`TCPD_EV_EOTREV] &&
             !(busy_r && ev[`TCPD_EV_ATEOT]))
            eot_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Read mux and bus response
   // -------------------------------------------------------------------
   reg [31:0] rd_nxt;
   always @*
   begin
      case (haddr[7:0])
         `TCPD_OFF_PKT0:   rd_nxt = {16'h0000, pkt_r[0]};
         `TCPD_OFF_PKT1:   rd_nxt = {16'h0000, pkt_r[1]};
         `TCPD_OFF_PKT2:   rd_nxt = {16'h0000, pkt_r[2]};
         `TCPD_OFF_PKT3:   rd_nxt = {16'h0000, pkt_r[3]};
         `TCPD_OFF_STATUS: rd_nxt = {24'h000000, ext_r, chars_ok_r, eot_r,
                                     at_bot_r, busy_r, tclass_r};
         `TCPD_OFF_XST0:   rd_nxt = {16'h0000, xst0_r};
         `TCPD_OFF_XST3:   rd_nxt = {16'h0000, xst3_r};
         `TCPD_OFF_CHAR:   rd_nxt = {16'h0000, char_r};
         `TCPD_OFF_XCHAR:  rd_nxt = {16'h0000, xchar_r};
         `TCPD_OFF_ADDR:   rd_nxt = {10'h000, xaddr_r};
         `TCPD_OFF_COUNT:  rd_nxt = {15'h0000, xcount_r};
         default:          rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (acc && !hwrite)
            hrdata <= rd_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: sim/tcpd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ---
// Port checker
// ---
module tcpd_checker
(
   input wire logic        hclk,            // Clock
   input wire logic        hresetn,         // Reset, low
   input wire logic        hsel,            // Select
   input wire logic [31:0] haddr,           // Address
   input wire logic [1:0]  htrans,          // Transfer
   input wire logic        hwrite,          // Direction
   input wire logic [2:0]  hsize,           // Size
   input wire logic [31:0] hwdata,          // Write data
   input wire logic        hready,          // Ready in
   input wire logic        ext_en,          // Strap
   input wire logic [31:0] hrdata,          // Read data
   input wire logic        hreadyout,       // Ready out
   input wire logic        hresp,           // Response
   input wire logic        motion_go,       // Start pulse
   input wire logic        buf_owned,       // Buffer owned
   input wire logic        subsystem_ready, // Ready
   input wire logic        done_irq,        // Completion
   input wire logic [2:0]  unit_sel,        // Transport
   input wire logic        high_speed       // Speed
);
   // Write address phases, all and to start or event offsets
   wire logic wr_ap = hsel & hready & htrans[1] & hwrite;
   wire logic go_ap = wr_ap & (haddr[7:0] == 8'h10);
   wire logic ev_ap = wr_ap & (haddr[7:0] == 8'h28);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pulses, causes and busy relations
   property p_go_pulse; motion_go |=> !motion_go; endproperty
   property p_irq_pulse; done_irq |=> !done_irq; endproperty
   property p_go_busy; motion_go |-> !subsystem_ready; endproperty
   property p_go_cause; motion_go |-> $past(go_ap, 2); endproperty
   property p_irq_ready; done_irq |-> subsystem_ready; endproperty
   property p_busy_cause; $fell(subsystem_ready) |-> motion_go; endproperty
   property p_done_cause; $rose(subsystem_ready) |-> $past(ev_ap, 2);
   endproperty
   property p_unit_cause;
      $changed({unit_sel, high_speed}) |-> $past(wr_ap, 2);
   endproperty
   a_go_pulse: assert property (p_go_pulse)
      else $error("start pulse too long");
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("completion pulse too long");
   a_go_busy: assert property (p_go_busy)
      else $error("ready during start");
   a_go_cause: assert property (p_go_cause)
      else $error("start without start write");
   a_irq_ready: assert property (p_irq_ready)
      else $error("completion while busy");
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy without start");
   a_done_cause: assert property (p_done_cause)
      else $error("ready without tape event");
   a_unit_cause: assert property (p_unit_cause)
      else $error("unit changed without write");
   c_go: cover property (motion_go);
   c_irq: cover property (done_irq);
   c_unit: cover property ($changed(unit_sel));
endmodule
`default_nettype wire

/* File: sim/tcpd_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ---
// Host bus master
// ---
module tcpd_host
(
   input  wire logic        hclk,   // Clock
   input  wire logic        hready, // Bus ready
   input  wire logic [31:0] hrdata, // Read data
   output var  logic        hsel,   // Select
   output var  logic [31:0] haddr,  // Address
   output var  logic [1:0]  htrans, // Transfer
   output var  logic        hwrite, // Direction
   output var  logic [2:0]  hsize,  // Size
   output var  logic [31:0] hwdata  // Write data
);
   initial
   begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   // One word, each phase held until ready is sampled
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h00000000, r);
   endtask
   // Whole four-word packet, then the start bit
   task automatic cmd(input logic [31:0] h, w1, w2, w3);
      wr(8'h00, h);
      wr(8'h04, w1);
      wr(8'h08, w2);
      wr(8'h0C, w3);
      wr(8'h10, 32'h00000001);
   endtask
endmodule
`default_nettype wire

/* File: sim/tcpd_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tcpd_tb_top;
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             ext_en = 1'b1;
   wire logic        hsel, hwrite, hreadyout, hresp, motion_go, buf_owned;
   wire logic        subsystem_ready, done_irq, high_speed;
   wire logic [31:0] haddr, hwdata, hrdata;
   wire logic [1:0]  htrans;
   wire logic [2:0]  hsize, unit_sel;
   int               n_mismatch = 0;
   int               samples_checked = 0;
   int               cyc = 0;
   int               n_irq = 0;
   int               n_go = 0;
   int               i;
   int               c;
   logic             ok;
   logic [31:0]      r, h, xc;
   localparam logic [31:0] hdr_rd = 32'h8001, hdr_rv = 32'h8101;
   localparam logic [31:0] hdr_wc = 32'h8004, hdr_wci = 32'h8084;
   localparam logic [31:0] hdr_wr = 32'h8005, hdr_wr2 = 32'h8205;
   localparam logic [31:0] hdr_sk = 32'h8208, hdr_rel = 32'h800A;
   localparam logic [31:0] hdr_bad = 32'h8041;
   localparam logic [18:0] rej = 19'h30000, bad_address_flag = 19'h30080;
   always #50 hclk = ~hclk;
   // Cycle budget and completion pulse count
   always @(posedge hclk)
   begin
      cyc++;
      if (done_irq === 1'b1) n_irq++;
      if (motion_go === 1'b1) n_go++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         close_out;
      end
   end
   tcpd_host u_host(.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));
   tcpd_top u_tcpd_top(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .ext_en(ext_en),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .motion_go(motion_go), .buf_owned(buf_owned),
      .subsystem_ready(subsystem_ready), .done_irq(done_irq),
      .unit_sel(unit_sel), .high_speed(high_speed));
   task automatic chk(input string n, input logic [31:0] x, g);
      samples_checked++;
      if (g !== x)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   // Expected class and length flags of a read
   function automatic logic [18:0] rexp(input int ln, input int cn);
      if (ln == cn)
         return 19'h00000;
      return {3'h2, 1'b0, ln < cn, 1'b0, ln > cn, 12'h000};
   endfunction
   function automatic logic aok(input logic x, input logic [15:0] w);
      return x ? (w[15:6] == 10'h000) : (w[15:2] == 14'h0000);
   endfunction
   // Packet, optional tape event, then class, status and pulses
   task automatic op(input logic [31:0] hd, w1, w2, w3,
      input logic [7:0] ev, input logic [16:0] ln, input logic [18:0] e,
      input logic [15:0] m, input int ir);
      int i0;
      int g0;
      logic [31:0] s;
      i0 = n_irq;
      g0 = n_go;
      u_host.cmd(hd, w1, w2, w3);
      if (ev != 8'h00) u_host.wr(8'h28, {ln, 7'h00, ev});
      u_host.rd(8'h14, s);
      if (e[18:16] != 3'h7) chk("class", {29'h0, e[18:16]}, {29'h0, s[2:0]});
      u_host.rd(8'h18, s);
      chk("xst0", {16'h0000, e[15:0] & m}, s & {16'h0000, m});
      chk("irq", 32'(ir), 32'(n_irq - i0));
      chk("go", {31'h0, ev != 8'h00}, 32'(n_go - g0));
      chk("ready", 32'h1, {31'h0, subsystem_ready});
      chk("resp", 32'h0, {31'h0, hresp});
   endtask
   task close_out;
      $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      r = $urandom(83);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk("unit", 32'h0, {29'h0, unit_sel});
      op(hdr_rd, 32'h1000, 32'h0, 32'h10, 8'h0, 17'h0, rej, 16'h0, 0);
      op(hdr_wc, 32'h101, 32'h0, 32'h6, 8'h0, 17'h0, rej, 16'h0, 0);
      op(hdr_wc, 32'h100, 32'h40, 32'h6, 8'h0, 17'h0, rej, 16'h0, 0);
      xc = $urandom & 32'h3F;
      u_host.wr(8'h20, 32'hD0);
      u_host.wr(8'h24, xc);
      op(hdr_wci, 32'h100, 32'h0, 32'hA, 8'h0, 17'h0, 19'h0, 16'h0, 1);
      chk("unit", {29'h0, xc[2:0]}, {29'h0, unit_sel});
      chk("speed", {31'h0, xc[5]}, {31'h0, high_speed});
      chk("owned", 32'h1, {31'h0, buf_owned});
      $display("test setup done");
      for (i = 0; i < 6; i++)
      begin
         h = $urandom;
         h = i[0] ? ((h | (32'h40 << (h % 10))) & 32'hFFFF) : (h & 32'h3F);
         ok = aok(1'b1, h[15:0]);
         xc = $urandom & 32'hFFFF;
         r = $urandom & 32'h3000;
         op(hdr_rd | r, xc, h, 32'h40, {7'h0, ok}, 17'h40, ok ? 19'h0 : bad_address_flag,
            16'h0080, 0);
         u_host.rd(8'h2C, r);
         if (ok) chk("addr", {10'h0, h[5:0], xc[15:0]}, r);
      end
      for (i = 0; i < 3; i++)
      begin
         c = $urandom_range(60000, 1);
         op(hdr_rd, 32'h0, 32'h0, c, 8'h1, 17'(c + i - 1), rexp(c + i - 1, c),
            16'h5000, 0);
      end
      op(hdr_rd | 32'h80, 32'h0, 32'h0, 32'h0, 8'h1, 17'h10000, 19'h0, 16'h5000, 1);
      op(hdr_rd, 32'h0, 32'h0, 32'h20, 8'h3, 17'h0, 19'h2C000, 16'hD000, 0);
      $display("test read done");
      op(hdr_rv, 32'h0, 32'h0, 32'h20, 8'hD, 17'h20, 19'h20000, 16'h0, 0);
      u_host.rd(8'h1C, r);
      chk("xst3", 32'h1, r & 32'h1);
      op(hdr_rv, 32'h0, 32'h0, 32'h20, 8'h0, 17'h0, 19'h30100, 16'h100, 0);
      op(hdr_wr2, 32'h0, 32'h0, 32'h8, 8'h0, 17'h0, rej, 16'h0, 0);
      op(hdr_wr, 32'h0, 32'h0, 32'h0, 8'h1, 17'h10000, 19'h0, 16'h1, 0);
      u_host.rd(8'h30, r);
      chk("count", 32'h10000, r);
      op(hdr_wr, 32'h0, 32'h0, 32'h8, 8'h11, 17'h8, 19'h20001, 16'h1, 0);
      op(hdr_wr, 32'h0, 32'h0, 32'h8, 8'h1, 17'h8, 19'h20001, 16'h1, 0);
      op(hdr_sk, 32'h5, 32'h0, 32'h0, 8'h40, 17'h0, 19'h70800, 16'h800, 0);
      op(hdr_rel, 32'h0, 32'h0, 32'h0, 8'h0, 17'h0, 19'h70000, 16'h0, 1);
      op(hdr_bad, 32'h0, 32'h0, 32'h8, 8'h0, 17'h0, rej, 16'h0, 0);
      $display("test write done");
      ext_en <= 1'b0;
      repeat (3) @(posedge hclk);
      op(hdr_rd, 32'h0, 32'h4, 32'h8, 8'h0, 17'h0, bad_address_flag, 16'h80, 0);
      op(hdr_rd, 32'h1234, 32'h3, 32'h8, 8'h1, 17'h8, 19'h0, 16'h80, 0);
      u_host.rd(8'h2C, r);
      chk("addr", 32'h31234, r);
      $display("test narrow done");
      close_out;
   end
endmodule
bind tcpd_top tcpd_checker u_chk(.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .ext_en(ext_en),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .motion_go(motion_go), .buf_owned(buf_owned),
   .subsystem_ready(subsystem_ready), .done_irq(done_irq),
   .unit_sel(unit_sel), .high_speed(high_speed));
`default_nettype wire
